/* rtl/i2cst_defines.svh */
// offsets, field positions and reset values of the i2c status block
//
// Operation
// - controller busy from issued START to STOP
// - controller busy holds through target clock stretch
// - controller busy low unless clocking; resets 0
// - bus busy bit 0 set by START
// - bus busy cleared only by STOP
// - target write address match sets bit 23
// - target read address match sets bit 22
// - lockout bit 15 set means FIFO locked
// - lockout set flushes all transmit entries
// - transmit writes discarded while lockout set
// - writing zero leaves event flags unchanged
// - mode bit one controller, zero target
`ifndef I2CST_DEFINES_SVH
`define I2CST_DEFINES_SVH

// register byte offsets
`define I2CST_CTRL_OFS 12'h000
`define I2CST_STATUS_OFS 12'h004
`define I2CST_FLAGS_OFS 12'h008
`define I2CST_MASK_OFS 12'h00c
`define I2CST_OWNADDR_OFS 12'h010
`define I2CST_TXDATA_OFS 12'h014
`define I2CST_RXDATA_OFS 12'h018

// control fields
`define I2CST_CTRL_EN 0
`define I2CST_CTRL_MODE 1

// status fields
`define I2CST_ST_BUSY 0
`define I2CST_ST_RXEM 1
`define I2CST_ST_RXFULL 2
`define I2CST_ST_TXEM 3
`define I2CST_ST_TXFULL 4
`define I2CST_ST_MSTBUSY 5

// event flag fields
`define I2CST_FL_LOCK 15
`define I2CST_FL_RDMATCH 22
`define I2CST_FL_WRMATCH 23

// reset values
`define I2CST_CTRL_RST 2'h0
`define I2CST_OWNADDR_RST 7'h00
`define I2CST_MASK_RST 32'h00000000

// address byte has eight bits
`define I2CST_ADDR_BITS 4'h8

`endif

/* rtl/i2cst_pkg.sv */
// types shared by the i2c status block
package i2cst_pkg;
    // bus condition detector states
    typedef enum logic [1:0] {
        I2CST_IDLE = 2'b00,
        I2CST_ADDR = 2'b01,
        I2CST_DATA = 2'b10
    } i2cst_det_e;
    typedef logic [31:0] i2cst_word_t;
endpackage

/* rtl/i2cst_cond_if.sv */
// bus condition events from the detector to the status core
`timescale 1ns/1ps
interface i2cst_cond_if;
    logic startSeen; // one-cycle pulse, START on the bus
    logic stopSeen; // one-cycle pulse, STOP on the bus
    logic addrValid; // one-cycle pulse, address byte complete
    logic addrRw; // direction bit of that byte, 1 is read
    logic [6:0] addrVal; // seven address bits
    modport det (output startSeen, stopSeen, addrValid, addrRw, addrVal);
    modport core (input startSeen, stopSeen, addrValid, addrRw, addrVal);
endinterface

/* rtl/i2cst_cond_det.sv */
// start, stop and address byte detector on synchronised bus lines
`timescale 1ns/1ps
module i2cst_cond_det
    import i2cst_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic sclS,
    input wire logic sdaS,
    i2cst_cond_if.det cond
);
    import i2cst_pkg::*;
`include "i2cst_defines.svh"

    logic sclPrev_q; // previous scl sample
    logic sdaPrev_q; // previous sda sample
    i2cst_det_e state_q; // where in the frame we are
    logic [3:0] bitCnt_q; // address bits seen
    logic [7:0] shift_q; // address shifter
    logic startNow; // start condition this cycle
    logic stopNow; // stop condition this cycle
    logic sclRise; // scl rising edge

    assign startNow = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
    assign stopNow = sclS & sclPrev_q & ~sdaPrev_q & sdaS;
    assign sclRise = sclS & ~sclPrev_q;

    ////////////////////////////////////////////////////////////////////
    // edge history
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // frame tracking; a repeated start restarts the address phase
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= I2CST_IDLE;
            bitCnt_q <= 4'h0;
            shift_q <= 8'h00;
        end else if (stopNow) begin
            state_q <= I2CST_IDLE;
        end else if (startNow) begin
            state_q <= I2CST_ADDR;
            bitCnt_q <= 4'h0;
        end else begin
            unique case (state_q)
                I2CST_IDLE: begin
                    // nothing to watch between frames
                end
                I2CST_ADDR: begin
                    if (sclRise) begin
                        shift_q <= {shift_q[6:0], sdaS};
                        bitCnt_q <= bitCnt_q + 4'h1;
                        if (bitCnt_q == `I2CST_ADDR_BITS - 4'h1) begin
                            state_q <= I2CST_DATA;
                        end
                    end
                end
                I2CST_DATA: begin
                    // data bytes are not decoded here
                end
                default: begin
                    state_q <= I2CST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered event pulses toward the core
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cond.startSeen <= 1'b0;
            cond.stopSeen <= 1'b0;
            cond.addrValid <= 1'b0;
            cond.addrRw <= 1'b0;
            cond.addrVal <= 7'h00;
        end else begin
            cond.startSeen <= startNow;
            cond.stopSeen <= stopNow;
            cond.addrValid <= 1'b0;
            if (!stopNow && !startNow && state_q == I2CST_ADDR && sclRise
                && bitCnt_q == `I2CST_ADDR_BITS - 4'h1) begin
                cond.addrValid <= 1'b1;
                cond.addrVal <= shift_q[6:0];
                cond.addrRw <= sdaS;
            end
        end
    end
endmodule

/* rtl/i2cst_top.sv */
// i2c status, fifo indicators and event flags behind an apb slave
`timescale 1ns/1ps
module i2cst_top
    import i2cst_pkg::*;
#(
    parameter int TX_DEPTH = 8,
    parameter int RX_DEPTH = 8
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire i2cst_pkg::i2cst_word_t pwdata,
    output i2cst_pkg::i2cst_word_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scl,
    input wire logic sda,
    input wire logic ctrlStart,
    input wire logic txLockReq,
    input wire logic txPop,
    input wire logic rxPush,
    output logic irq
);
    import i2cst_pkg::*;
`include "i2cst_defines.svh"

    localparam int TXW = $clog2(TX_DEPTH + 1);
    localparam int RXW = $clog2(RX_DEPTH + 1);

    logic sclMeta_q, sclSync_q; // scl synchroniser
    logic sdaMeta_q, sdaSync_q; // sda synchroniser
    logic [1:0] ctrl_q; // enable and mode select
    logic [6:0] ownAddr_q; // own target address
    i2cst_word_t mask_q; // interrupt mask, flag layout
    logic busy_q; // bus transaction in progress
    logic mstBusy_q; // this block is controlling the bus
    logic wrMatch_q; // target write address match
    logic rdMatch_q; // target read address match
    logic txLock_q; // transmit fifo locked
    logic [TXW-1:0] txCount_q; // transmit occupancy
    logic [RXW-1:0] rxCount_q; // receive occupancy
    i2cst_word_t prdata_q; // read data register
    logic pready_q; // access phase answer
    logic pslverr_q; // unmapped address answer
    logic irq_q; // interrupt level
    logic setupPh; // setup cycle of a transfer
    logic wrEn; // write takes effect this edge
    logic rdEn; // read completes this edge
    logic mapped; // address decodes to a register
    logic enQ; // peripheral enabled
    logic ctlMode; // controller mode selected
    logic txEmpty, txFull, rxEmpty, rxFull; // fifo indicators
    logic matchHit; // address equals own address in target mode
    logic flagWr; // write to event flag register
    logic txWr; // write to transmit data register
    i2cst_word_t flagsRd; // event flags as read
    i2cst_word_t statusRd; // status as read
    i2cst_word_t rdMux; // selected read data

    i2cst_cond_if cond ();

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers; only the second stage is read
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sclMeta_q <= 1'b1;
            sclSync_q <= 1'b1;
            sdaMeta_q <= 1'b1;
            sdaSync_q <= 1'b1;
        end else begin
            sclMeta_q <= scl;
            sclSync_q <= sclMeta_q;
            sdaMeta_q <= sda;
            sdaSync_q <= sdaMeta_q;
        end
    end

    i2cst_cond_det u_det (
        .mclk(mclk),
        .nrst(nrst),
        .sclS(sclSync_q),
        .sdaS(sdaSync_q),
        .cond(cond.det)
    );

    ////////////////////////////////////////////////////////////////////
    // apb decode; answer comes one cycle after setup
    assign setupPh = psel & ~penable;
    assign wrEn = psel & penable & pready_q & pwrite;
    assign rdEn = psel & penable & pready_q & ~pwrite;
    assign mapped = (paddr == `I2CST_CTRL_OFS) ||
        (paddr == `I2CST_STATUS_OFS) || (paddr == `I2CST_FLAGS_OFS) ||
        (paddr == `I2CST_MASK_OFS) || (paddr == `I2CST_OWNADDR_OFS) ||
        (paddr == `I2CST_TXDATA_OFS) || (paddr == `I2CST_RXDATA_OFS);
    assign flagWr = wrEn && paddr == `I2CST_FLAGS_OFS;
    assign txWr = wrEn && paddr == `I2CST_TXDATA_OFS;
    assign enQ = ctrl_q[`I2CST_CTRL_EN];
    assign ctlMode = ctrl_q[`I2CST_CTRL_MODE];

    assign txEmpty = (txCount_q == '0);
    assign txFull = (txCount_q == TXW'(TX_DEPTH));
    assign rxEmpty = (rxCount_q == '0);
    assign rxFull = (rxCount_q == RXW'(RX_DEPTH));

    // matches only count in target mode
    assign matchHit = cond.addrValid & enQ & ~ctlMode &
        (cond.addrVal == ownAddr_q);

    // status and flag images, reserved bits zero
    always_comb begin
        statusRd = '0;
        statusRd[`I2CST_ST_BUSY] = busy_q;
        statusRd[`I2CST_ST_RXEM] = rxEmpty;
        statusRd[`I2CST_ST_RXFULL] = rxFull;
        statusRd[`I2CST_ST_TXEM] = txEmpty;
        statusRd[`I2CST_ST_TXFULL] = txFull;
        statusRd[`I2CST_ST_MSTBUSY] = mstBusy_q;
        flagsRd = '0;
        flagsRd[`I2CST_FL_LOCK] = txLock_q;
        flagsRd[`I2CST_FL_RDMATCH] = rdMatch_q;
        flagsRd[`I2CST_FL_WRMATCH] = wrMatch_q;
    end

    // read mux; unmapped reads give zero
    always_comb begin
        unique case (paddr)
            `I2CST_CTRL_OFS: rdMux = {30'h0, ctrl_q};
            `I2CST_STATUS_OFS: rdMux = statusRd;
            `I2CST_FLAGS_OFS: rdMux = flagsRd;
            `I2CST_MASK_OFS: rdMux = mask_q;
            `I2CST_OWNADDR_OFS: rdMux = {25'h0, ownAddr_q};
            default: rdMux = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // bus answer registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= setupPh;
            pslverr_q <= setupPh & ~mapped;
            if (setupPh) begin
                prdata_q <= pwrite ? '0 : rdMux;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software control registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `I2CST_CTRL_RST;
            ownAddr_q <= `I2CST_OWNADDR_RST;
            mask_q <= `I2CST_MASK_RST;
        end else if (wrEn) begin
            if (paddr == `I2CST_CTRL_OFS) begin
                ctrl_q <= pwdata[1:0];
            end
            if (paddr == `I2CST_OWNADDR_OFS) begin
                ownAddr_q <= pwdata[6:0];
            end
            if (paddr == `I2CST_MASK_OFS) begin
                mask_q <= pwdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus activity, both modes
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy_q <= 1'b0;
        // only a stop ends the transaction
        end else if (cond.stopSeen) begin
            busy_q <= 1'b0;
        // any start while enabled marks the bus busy
        end else if (cond.startSeen && enQ) begin
            busy_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // controller activity
    // scl ignored, so stretching cannot drop it
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            mstBusy_q <= 1'b0;
        // low whenever not the clocking controller
        end else if (!ctlMode || !enQ || cond.stopSeen) begin
            mstBusy_q <= 1'b0;
        // set by the start this block issues
        end else if (ctrlStart) begin
            mstBusy_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sticky event flags; a set in the clearing cycle wins
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            wrMatch_q <= 1'b0;
            rdMatch_q <= 1'b0;
            txLock_q <= 1'b0;
        end else begin
            wrMatch_q <= (wrMatch_q &
                ~(flagWr & pwdata[`I2CST_FL_WRMATCH])) |
                (matchHit & ~cond.addrRw);
            rdMatch_q <= (rdMatch_q &
                ~(flagWr & pwdata[`I2CST_FL_RDMATCH])) |
                (matchHit & cond.addrRw);
            txLock_q <= (txLock_q &
                ~(flagWr & pwdata[`I2CST_FL_LOCK])) | txLockReq;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmit occupancy; data words themselves are not kept here
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            txCount_q <= '0;
        end else if (txLockReq) begin
            txCount_q <= '0;
        end else begin
            // locked fifo takes nothing; writes dropped
            if (txWr && !txLock_q && !txFull && !(txPop && !txEmpty)) begin
                txCount_q <= txCount_q + TXW'(1);
            end else if (txPop && !txEmpty && !(txWr && !txLock_q)) begin
                txCount_q <= txCount_q - TXW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receive occupancy; reading the data register pops one
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rxCount_q <= '0;
        end else begin
            if (rxPush && !rxFull &&
                !(rdEn && paddr == `I2CST_RXDATA_OFS && !rxEmpty)) begin
                rxCount_q <= rxCount_q + RXW'(1);
            end else if (rdEn && paddr == `I2CST_RXDATA_OFS && !rxEmpty
                && !(rxPush && !rxFull)) begin
                rxCount_q <= rxCount_q - RXW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // interrupt level from unmasked flags
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flagsRd & mask_q);
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

    ////////////////////////////////////////////////////////////////////
    // checks
    a_mst_busy_set: assert property (
        @(posedge mclk) disable iff (!nrst)
        ctrlStart && enQ && ctlMode && !cond.stopSeen |=> mstBusy_q)
        else $error("controller busy not set by start");
    a_mst_busy_hold: assert property (
        @(posedge mclk) disable iff (!nrst)
        mstBusy_q && ctlMode && enQ && !cond.stopSeen |=> mstBusy_q)
        else $error("controller busy dropped mid transaction");
    a_mst_busy_mode: assert property (
        @(posedge mclk) disable iff (!nrst)
        !ctlMode |=> !mstBusy_q)
        else $error("controller busy outside controller mode");
    a_bus_busy_set: assert property (
        @(posedge mclk) disable iff (!nrst)
        cond.startSeen && enQ && !cond.stopSeen |=> busy_q)
        else $error("bus busy not set by start");
    a_bus_busy_end: assert property (
        @(posedge mclk) disable iff (!nrst)
        $fell(busy_q) |-> $past(cond.stopSeen))
        else $error("bus busy cleared without stop");
    a_wr_match_set: assert property (
        @(posedge mclk) disable iff (!nrst)
        matchHit && !cond.addrRw |=> wrMatch_q)
        else $error("write match flag not set");
    a_rd_match_set: assert property (
        @(posedge mclk) disable iff (!nrst)
        matchHit && cond.addrRw |=> rdMatch_q)
        else $error("read match flag not set");
    a_lock_flush: assert property (
        @(posedge mclk) disable iff (!nrst)
        txLockReq |=> txEmpty ##1 (txEmpty || !txLock_q))
        else $error("lockout did not flush transmit fifo");
    a_lock_discard: assert property (
        @(posedge mclk) disable iff (!nrst)
        txLock_q |=> txCount_q <= $past(txCount_q))
        else $error("transmit write accepted while locked");
    a_flag_sticky: assert property (
        @(posedge mclk) disable iff (!nrst)
        txLock_q && !(flagWr && pwdata[`I2CST_FL_LOCK]) |=> txLock_q)
        else $error("lockout flag lost without clear");
    a_flag_clear: assert property (
        @(posedge mclk) disable iff (!nrst)
        flagWr && pwdata[`I2CST_FL_RDMATCH] && !matchHit |=> !rdMatch_q)
        else $error("read match flag not cleared by one");
endmodule

/* verification/i2cst_bus_model.sv */
// behavioural far-side party on the two-wire bus: start, stop, bytes
`timescale 1ns/1ps
module i2cst_bus_model (
    output logic scl,
    output logic sda
);
    // both lines rest at the pull-up level outside frames
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    // start: data falls while clock is high; from a low clock the data
    // line is raised first so that a repeated start is also seen
    task automatic startCond();
        sda = 1'b1;
        #100 scl = 1'b1;
        #100 sda = 1'b0;
        #100 scl = 1'b0;
        #100;
    endtask

    // byte msb first, then a ninth clock with data released
    task automatic sendByte(input logic [7:0] b);
        for (int i = 8; i >= 0; i--) begin
            sda = (i > 0) ? b[i-1] : 1'b1;
            #100 scl = 1'b1;
            #200 scl = 1'b0;
            #100;
        end
    endtask

    // clock stays low, as a slow target would hold it
    task automatic stretch(input int ns);
        scl = 1'b0;
        #(ns);
    endtask

    // stop: data rises while clock is high, then idle
    task automatic stopCond();
        sda = 1'b0;
        #100 scl = 1'b1;
        #100 sda = 1'b1;
        #200;
    endtask
endmodule

/* verification/testbench.sv */
// self-checking bench for the i2c status and event flag block
`timescale 1ns/1ps
`include "i2cst_defines.svh"
module testbench;
    import i2cst_pkg::*;
    logic mclk = 1'b0; // 20 mhz system clock
    logic nrst = 1'b0; // active low reset
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    i2cst_word_t pwdata = 32'h0;
    i2cst_word_t prdata;
    logic pready;
    logic pslverr;
    wire scl; // link lines from the far-side model
    wire sda;
    logic ctrlStart = 1'b0; // sequencer event pulses
    logic txLockReq = 1'b0;
    logic txPop = 1'b0;
    logic rxPush = 1'b0;
    logic irq;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    i2cst_word_t rdv; // last read data
    logic errv; // last slave error

    always #25 mclk = ~mclk;

    i2cst_top i2cst_top_inst (.mclk(mclk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl(scl), .sda(sda), .ctrlStart(ctrlStart),
        .txLockReq(txLockReq), .txPop(txPop), .rxPush(rxPush), .irq(irq));

    i2cst_bus_model i2cst_bus_model_inst (.scl(scl), .sda(sda));

    ////////////////////////////////////////////////////////////////////
    // verdict and end of run, reached from the sequence or the timeout
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // hang guard, well above the roughly 650 cycles expected
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            test_done();
        end
    end

    task automatic chkWord(input i2cst_word_t got, input i2cst_word_t exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////
    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
            input i2cst_word_t d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input i2cst_word_t d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input i2cst_word_t exp);
        apb(1'b0, a, 32'h0);
        chkWord(rdv, exp);
    endtask

    // one-cycle event pulse: 0 start, 1 lockout, 2 pop, 3 push
    task automatic pulse(input int k);
        @(posedge mclk);
        case (k)
            0: ctrlStart <= 1'b1;
            1: txLockReq <= 1'b1;
            2: txPop <= 1'b1;
            default: rxPush <= 1'b1;
        endcase
        @(posedge mclk);
        {ctrlStart, txLockReq, txPop, rxPush} <= 4'h0;
    endtask

    // let synchronised link events reach the registers
    task automatic settle();
        repeat (10) @(posedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////
    // reset values, read-only status, unmapped address
    task automatic tResetMap();
        rd(`I2CST_STATUS_OFS, 32'h0000000a);
        rd(`I2CST_FLAGS_OFS, 32'h0);
        wr(`I2CST_STATUS_OFS, 32'hffffffff);
        rd(`I2CST_STATUS_OFS, 32'h0000000a);
        apb(1'b0, 12'h0fc, 32'h0);
        chkBit(errv, 1'b1);
        chkWord(rdv, 32'h0);
    endtask

    // target mode: busy, both matches, w1c, masked interrupt
    task automatic tTarget();
        wr(`I2CST_CTRL_OFS, 32'h1);
        wr(`I2CST_OWNADDR_OFS, 32'h5a);
        wr(`I2CST_MASK_OFS, 32'h00800000);
        i2cst_bus_model_inst.startCond();
        settle();
        rd(`I2CST_STATUS_OFS, 32'h0000000b);
        i2cst_bus_model_inst.sendByte(8'h24);
        settle();
        rd(`I2CST_FLAGS_OFS, 32'h0);
        i2cst_bus_model_inst.startCond();
        i2cst_bus_model_inst.sendByte(8'hb4);
        settle();
        rd(`I2CST_FLAGS_OFS, 32'h00800000);
        chkBit(irq, 1'b1);
        wr(`I2CST_FLAGS_OFS, 32'h0);
        rd(`I2CST_FLAGS_OFS, 32'h00800000);
        wr(`I2CST_FLAGS_OFS, 32'h00800000);
        rd(`I2CST_FLAGS_OFS, 32'h0);
        chkBit(irq, 1'b0);
        i2cst_bus_model_inst.startCond();
        i2cst_bus_model_inst.sendByte(8'hb5);
        settle();
        rd(`I2CST_FLAGS_OFS, 32'h00400000);
        chkBit(irq, 1'b0);
        rd(`I2CST_STATUS_OFS, 32'h0000000b);
        i2cst_bus_model_inst.stopCond();
        settle();
        rd(`I2CST_STATUS_OFS, 32'h0000000a);
        wr(`I2CST_FLAGS_OFS, 32'h00400000);
    endtask

    // controller mode: busy through stretching, no match, stop ends it
    task automatic tController();
        wr(`I2CST_CTRL_OFS, 32'h3);
        pulse(0);
        i2cst_bus_model_inst.startCond();
        settle();
        rd(`I2CST_STATUS_OFS, 32'h0000002b);
        i2cst_bus_model_inst.sendByte(8'hb4);
        i2cst_bus_model_inst.stretch(3000);
        rd(`I2CST_STATUS_OFS, 32'h0000002b);
        rd(`I2CST_FLAGS_OFS, 32'h0);
        i2cst_bus_model_inst.stopCond();
        settle();
        rd(`I2CST_STATUS_OFS, 32'h0000000a);
    endtask

    // transmit fill, lockout flush, discarded writes, release
    task automatic tLockout();
        for (int i = 0; i < 8; i++) wr(`I2CST_TXDATA_OFS, i);
        rd(`I2CST_STATUS_OFS, 32'h00000012);
        pulse(1);
        rd(`I2CST_FLAGS_OFS, 32'h00008000);
        rd(`I2CST_STATUS_OFS, 32'h0000000a);
        wr(`I2CST_TXDATA_OFS, 32'h55);
        rd(`I2CST_STATUS_OFS, 32'h0000000a);
        wr(`I2CST_FLAGS_OFS, 32'h00008000);
        rd(`I2CST_FLAGS_OFS, 32'h0);
        wr(`I2CST_TXDATA_OFS, 32'h55);
        rd(`I2CST_STATUS_OFS, 32'h00000002);
        pulse(2);
        rd(`I2CST_STATUS_OFS, 32'h0000000a);
    endtask

    // receive fill to full, one pop
    task automatic tReceive();
        repeat (8) pulse(3);
        rd(`I2CST_STATUS_OFS, 32'h0000000c);
        rd(`I2CST_RXDATA_OFS, 32'h0);
        rd(`I2CST_STATUS_OFS, 32'h00000008);
    endtask

    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (12) @(posedge mclk);
        nrst <= 1'b1;
        tResetMap();
        tTarget();
        tController();
        tLockout();
        tReceive();
        test_done();
    end
endmodule
